// file: hw/scc_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Manual forward held runs screen forward
// - Manual forward press runs, valves closed
// - Manual reverse held runs screen reverse
// - Manual reverse press runs, valves closed
// - Valve buttons toggle open and closed
// - Valve toggles accepted only in manual
// - Trigger starts one screen rotation
// - Trigger starts one press treatment cycle
// - Overload reverses screen for set interval
// - Too many overloads in window stop screen
// - Warning current in forward alarms, press keeps running
// - Shutdown current stops press with alarm
// - Low running current flags spiral breakage
// - Emergency stop halts machine in any mode
// - Reset button and clear command clear alarms; estop release clears only its own alarm
// - High level warns and rotates screen once
// - Alarms logged to history once cleared
// - Press out of auto with screen in auto alarms after delay
// - Count starts, runtime and press cycles
// - Alternating start swaps after rotation plus delay
// - High level suspends alternation until both low
// - Alternation off if not auto, fault, disabled
module scc_ctrl (
  // Clock and reset
  input  wire  logic                       clk_sys_i,
  input  wire  logic                       rst_n_i,
  // Field pins and settings
  input  wire  scc_pkg::scc_pin_s          pin_i,
  input  wire  scc_pkg::scc_cfg_s          cfg_i,
  // Digitised readings
  input  wire  logic [1:0][scc_pkg::LW-1:0] torque_i,
  input  wire  logic [1:0][scc_pkg::LW-1:0] cur_i,
  input  wire  logic [1:0][scc_pkg::LW-1:0] level_i,
  // Operator and automatic commands, one-cycle pulses
  input  wire  logic [1:0]                 start_req_i,
  input  wire  logic [1:0]                 scr_trig_i,
  input  wire  logic [1:0]                 prs_trig_i,
  input  wire  logic [1:0]                 wash_tgl_i,
  input  wire  logic [1:0]                 flush_tgl_i,
  input  wire  logic                       alarm_clr_i,
  // Motor and valve drives
  output logic [1:0]                       scr_fwd_o,
  output logic [1:0]                       scr_rev_o,
  output logic [1:0]                       prs_fwd_o,
  output logic [1:0]                       prs_rev_o,
  output logic [1:0]                       wash_vlv_o,
  output logic [1:0]                       flush_vlv_o,
  // Alarms and history
  output logic [scc_pkg::NA-1:0]           alarm_o,
  output logic                             hist_we_o,
  output logic [scc_pkg::NA-1:0]           hist_mask_o,
  output logic [scc_pkg::TW-1:0]           hist_time_o,
  // Statistics and alternation
  output logic [scc_pkg::NM-1:0][scc_pkg::CW-1:0] starts_o,
  output logic [scc_pkg::NM-1:0][scc_pkg::TW-1:0] runtime_o,
  output logic [1:0][scc_pkg::CW-1:0]      cycles_o,
  output logic                             alt_turn_o
);
  import scc_pkg::*;

  // Count of live overload slots
  function automatic logic [2:0] popcnt(input logic [OD-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < OD; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations
  scc_pin_s            ps1, ps2, ps3;     // Synchroniser and edge stage
  logic [TW-1:0]       now_reg;           // Free-running timestamp
  logic [NM-1:0]       off, man, aut, est;
  logic [1:0]          home_rise, stop_s, stop_p, ovl_ev, trip;
  logic [1:0]          ovl_d_reg, hlv_d_reg, hlv_rise, go, allowed;
  logic [1:0]          rot_done, pdone, vt_reg, ft_reg, crt_set;
  logic                btn_rise, susp;
  logic [NM-1:0]       est_rel;
  scc_scr_e [1:0]      st_reg;            // Screen sequence
  scc_prs_e [1:0]      pst_reg;           // Press sequence
  logic [1:0][TW-1:0]  tmr_reg, ptmr_reg, ctmr_reg;
  logic [1:0][OD-1:0]  tv_reg, keep;      // Overload slot valid
  logic [1:0][OD-1:0][TW-1:0] ts_reg;     // Overload timestamps
  logic [NM-1:0]       mf_next, mr_next, mf_reg, mr_reg, on_d_reg;
  logic [1:0]          wn_next, fn_next, wv_reg, fv_reg;
  logic [NA-1:0]       alarm_reg, alarm_next, a_set, a_clr;
  logic                turn_reg, apend_reg, hilat_reg;
  logic [TW-1:0]       adly_reg;
  logic                hwe_reg;
  logic [NA-1:0]       hmask_reg;
  logic [TW-1:0]       htime_reg;
  logic [NM-1:0][CW-1:0] starts_reg;
  logic [NM-1:0][TW-1:0] rt_reg;
  logic [1:0][CW-1:0]  cyc_reg;

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser; the third stage only feeds edge detection
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ps1 <= '0;
      ps2 <= '0;
      ps3 <= '0;
    end else begin
      ps1 <= pin_i;
      ps2 <= ps1;
      ps3 <= ps2;
    end
  end

  // Timestamp for overload window and history
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) now_reg <= RST_T;
    else          now_reg <= now_reg + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // Decoded selectors; both contacts made decodes as neither manual, automatic nor off
  always_comb begin
    man       = ps2.man & ~ps2.aut;
    aut       = ps2.aut & ~ps2.man;
    off       = ~ps2.man & ~ps2.aut;
    est       = ps2.estop;
    est_rel   = ~ps2.estop & ps3.estop;
    btn_rise  = ps2.rst_btn & ~ps3.rst_btn;
    home_rise = ps2.home & ~ps3.home;
    stop_s    = est[1:0] | alarm_reg[A_OVL+:2];
    stop_p    = est[3:2] | alarm_reg[A_SHT+:2];
    susp = ~cfg_i.alt_en | hilat_reg | ~(aut[0] & aut[1])
         | (|stop_s);
    allowed[0] = susp | (~apend_reg & ~turn_reg);
    allowed[1] = susp | (~apend_reg & turn_reg);
    for (int s = 0; s < 2; s++) begin
      ovl_ev[s]   = (torque_i[s] >= cfg_i.torque_thr) & ~ovl_d_reg[s];
      hlv_rise[s] = (level_i[s] >= cfg_i.hi_warn) & ~hlv_d_reg[s];
      // Trigger ignores the level and the alternation gate
      go[s] = scr_trig_i[s] | hlv_rise[s]
            | (start_req_i[s] & allowed[s]);
      rot_done[s] = (st_reg[s] == S_ROT) & home_rise[s] & ~ovl_ev[s];
      pdone[s] = (pst_reg[s] == P_RUN) & aut[2+s] & ~stop_p[s]
               & ((ptmr_reg[s] + 32'h1) >= cfg_i.cyc_time);
      for (int k = 0; k < OD; k++) begin
        // Slots older than the window drop out
        keep[s][k] = tv_reg[s][k]
                   & ((now_reg - ts_reg[s][k]) < cfg_i.ovl_win);
      end
      trip[s] = popcnt(tv_reg[s]) >= cfg_i.ovl_lim;
    end
  end

  // Edge memories for torque and high level
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ovl_d_reg <= 2'h0;
      hlv_d_reg <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        ovl_d_reg[s] <= torque_i[s] >= cfg_i.torque_thr;
        hlv_d_reg[s] <= level_i[s] >= cfg_i.hi_warn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Screen sequence: one rotation to home, timed overload reverse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      // Element by element, so each enum gets an enum value
      for (int s = 0; s < 2; s++) begin
        st_reg[s] <= S_IDLE;
      end
      tmr_reg <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (off[s] | stop_s[s]) begin
          st_reg[s] <= S_IDLE;
        end else begin
          unique case (st_reg[s])
            S_IDLE: begin
              if (ovl_ev[s] & mf_reg[s]) begin
                st_reg[s]  <= S_REV;
                tmr_reg[s] <= RST_T;
              end else if (aut[s] & go[s]) begin
                st_reg[s]  <= S_ROT;
              end
            end
            S_ROT: begin
              if (ovl_ev[s]) begin
                st_reg[s]  <= S_REV;
                tmr_reg[s] <= RST_T;
              end else if (home_rise[s] | ~aut[s]) begin
                st_reg[s]  <= S_IDLE;
              end
            end
            S_REV: begin
              tmr_reg[s] <= tmr_reg[s] + 32'h1;
              if ((tmr_reg[s] + 32'h1) >= cfg_i.rev_time) begin
                st_reg[s] <= aut[s] ? S_ROT : S_IDLE;
              end
            end
          endcase
        end
      end
    end
  end

  // Overload timestamps; a trip empties the window
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tv_reg <= '0;
      ts_reg <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (trip[s]) begin
          tv_reg[s] <= '0;
        end else if (ovl_ev[s]) begin
          tv_reg[s] <= {keep[s][OD-2:0], 1'b1};
          ts_reg[s] <= {ts_reg[s][OD-2:0], now_reg};
        end else begin
          tv_reg[s] <= keep[s];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Press treatment cycle, launched from automatic only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < 2; k++) begin
        pst_reg[k] <= P_IDLE;
      end
      ptmr_reg <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (~aut[2+k] | stop_p[k]) begin
          pst_reg[k] <= P_IDLE;
        end else begin
          unique case (pst_reg[k])
            P_IDLE: begin
              if (prs_trig_i[k]) begin
                pst_reg[k]  <= P_RUN;
                ptmr_reg[k] <= RST_T;
              end
            end
            P_RUN: begin
              ptmr_reg[k] <= ptmr_reg[k] + 32'h1;
              if (pdone[k]) pst_reg[k] <= P_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Manual valve toggles; forgotten once the press leaves manual
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      vt_reg <= 2'h0;
      ft_reg <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!man[2+k]) begin
          vt_reg[k] <= 1'b0;
          ft_reg[k] <= 1'b0;
        end else begin
          if (wash_tgl_i[k])  vt_reg[k] <= ~vt_reg[k];
          if (flush_tgl_i[k]) ft_reg[k] <= ~ft_reg[k];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Drive decisions; forward wins if both contacts read made
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      mf_next[s] = ~off[s] & ~stop_s[s] & ((st_reg[s] == S_ROT)
        | (man[s] & ps2.fwd[s] & (st_reg[s] != S_REV)));
      mr_next[s] = ~off[s] & ~stop_s[s] & ((st_reg[s] == S_REV)
        | (man[s] & ps2.rev[s] & ~ps2.fwd[s]));
      mf_next[2+s] = ~off[2+s] & ~stop_p[s]
        & ((pst_reg[s] == P_RUN) | (man[2+s] & ps2.fwd[2+s]));
      mr_next[2+s] = ~off[2+s] & ~stop_p[s] & man[2+s]
        & ps2.rev[2+s] & ~ps2.fwd[2+s];
      // Valves stay shut while the screw is jogged by hand
      wn_next[s] = ~off[2+s] & ~est[2+s]
        & ((man[2+s] & vt_reg[s] & ~ps2.fwd[2+s] & ~ps2.rev[2+s])
         | ((pst_reg[s] == P_RUN) & aut[2+s]
            & (ptmr_reg[s] < cfg_i.wash_time)));
      fn_next[s] = ~off[2+s] & ~est[2+s] & man[2+s] & ft_reg[s]
        & ~ps2.fwd[2+s] & ~ps2.rev[2+s];
    end
  end

  // Output drive registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mf_reg <= '0;
      mr_reg <= '0;
      wv_reg <= 2'h0;
      fv_reg <= 2'h0;
    end else begin
      mf_reg <= mf_next;
      mr_reg <= mr_next;
      wv_reg <= wn_next;
      fv_reg <= fn_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Out-of-auto timer for each press
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctmr_reg <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!(aut[k] & ~aut[2+k])) ctmr_reg[k] <= RST_T;
        else if (!crt_set[k])      ctmr_reg[k] <= ctmr_reg[k] + 32'h1;
      end
    end
  end

  // Alarm sets and clears; a set in the clearing cycle survives
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      crt_set[k] = aut[k] & ~aut[2+k]
                 & (ctmr_reg[k] >= cfg_i.crt_dly);
    end
    a_set = '0;
    a_set[A_OVL+:2] = trip;
    for (int s = 0; s < 2; s++) begin
      a_set[A_HLV+s] = level_i[s] >= cfg_i.hi_warn;
      a_set[A_WRN+s] = mf_reg[2+s] & (cur_i[s] >= cfg_i.cur_warn);
      a_set[A_SHT+s] = (mf_reg[2+s] | mr_reg[2+s])
                     & (cur_i[s] >= cfg_i.cur_shut);
      a_set[A_LOW+s] = (mf_reg[2+s] | mr_reg[2+s])
                     & (cur_i[s] < cfg_i.cur_low);
    end
    a_set[A_EST+:NM] = est;
    a_set[A_CRT+:2]  = crt_set;
    a_clr = {NA{btn_rise | alarm_clr_i}};
    a_clr[A_EST+:NM] = a_clr[A_EST+:NM] | est_rel;
    alarm_next = (alarm_reg & ~a_clr) | a_set;
  end

  // Active list and history hand-off of cleared alarms
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      alarm_reg <= '0;
      hwe_reg   <= 1'b0;
      hmask_reg <= '0;
      htime_reg <= RST_T;
    end else begin
      alarm_reg <= alarm_next;
      hwe_reg   <= |(alarm_reg & ~alarm_next);
      hmask_reg <= alarm_reg & ~alarm_next;
      htime_reg <= now_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alternating start: turn passes after rotation plus delay
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      turn_reg  <= 1'b0;
      apend_reg <= 1'b0;
      adly_reg  <= RST_T;
      hilat_reg <= 1'b0;
    end else begin
      if ((level_i[0] > cfg_i.alt_high) | (level_i[1] > cfg_i.alt_high))
        hilat_reg <= 1'b1;
      else if ((level_i[0] < cfg_i.cont_off) &
               (level_i[1] < cfg_i.cont_off))
        hilat_reg <= 1'b0;
      if (susp) begin
        apend_reg <= 1'b0;
      end else if (apend_reg) begin
        adly_reg <= adly_reg + 32'h1;
        if ((adly_reg + 32'h1) >= cfg_i.alt_dly) begin
          turn_reg  <= ~turn_reg;
          apend_reg <= 1'b0;
        end
      end else if (rot_done[turn_reg]) begin
        apend_reg <= 1'b1;
        adly_reg  <= RST_T;
      end
    end
  end

  // Starts, runtime and completed cycles
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      on_d_reg   <= '0;
      starts_reg <= '0;
      rt_reg     <= '0;
      cyc_reg    <= '0;
    end else begin
      on_d_reg <= mf_reg | mr_reg;
      for (int m = 0; m < NM; m++) begin
        if ((mf_reg[m] | mr_reg[m]) & ~on_d_reg[m])
          starts_reg[m] <= starts_reg[m] + 16'h1;
        if (mf_reg[m] | mr_reg[m])
          rt_reg[m] <= rt_reg[m] + 32'h1;
      end
      for (int k = 0; k < 2; k++) begin
        if (pdone[k]) cyc_reg[k] <= cyc_reg[k] + 16'h1;
      end
    end
  end

  // Port drive from registers
  assign scr_fwd_o   = mf_reg[1:0];
  assign scr_rev_o   = mr_reg[1:0];
  assign prs_fwd_o   = mf_reg[3:2];
  assign prs_rev_o   = mr_reg[3:2];
  assign wash_vlv_o  = wv_reg;
  assign flush_vlv_o = fv_reg;
  assign alarm_o     = alarm_reg;
  assign hist_we_o   = hwe_reg;
  assign hist_mask_o = hmask_reg;
  assign hist_time_o = htime_reg;
  assign starts_o    = starts_reg;
  assign runtime_o   = rt_reg;
  assign cycles_o    = cyc_reg;
  assign alt_turn_o  = turn_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_off_dead;
    off[0] |=> !scr_fwd_o[0] && !scr_rev_o[0];
  endproperty
  a_off_dead: assert property (p_off_dead)
    else $error("screen driven while selector off");

  property p_man_fwd;
    man[0] && ps2.fwd[0] && !stop_s[0] && st_reg[0] == S_IDLE
      |=> scr_fwd_o[0] && !scr_rev_o[0];
  endproperty
  a_man_fwd: assert property (p_man_fwd)
    else $error("manual forward not driven");

  property p_man_rev;
    man[0] && ps2.rev[0] && !ps2.fwd[0] && !stop_s[0] |=> scr_rev_o[0];
  endproperty
  a_man_rev: assert property (p_man_rev)
    else $error("manual reverse not driven");

  property p_jog_dry;
    man[2] && (ps2.fwd[2] || ps2.rev[2])
      |=> !wash_vlv_o[0] && !flush_vlv_o[0];
  endproperty
  a_jog_dry: assert property (p_jog_dry)
    else $error("valve open during manual jog");

  property p_est;
    est[2] |=> !prs_fwd_o[0] && !prs_rev_o[0] && !wash_vlv_o[0];
  endproperty
  a_est: assert property (p_est)
    else $error("press not halted by emergency stop");

  sequence s_ovl_hit;
    st_reg[0] == S_ROT && ovl_ev[0] && !off[0] && !stop_s[0];
  endsequence
  property p_ovl_rev;
    s_ovl_hit |=> st_reg[0] == S_REV ##1 scr_rev_o[0];
  endproperty
  a_ovl_rev: assert property (p_ovl_rev)
    else $error("overload did not reverse screen");

  property p_trip;
    trip[0] |=> alarm_o[A_OVL] ##1 !scr_fwd_o[0] && !scr_rev_o[0];
  endproperty
  a_trip: assert property (p_trip)
    else $error("overload trip did not stop screen");

  property p_shut;
    alarm_o[A_SHT] |=> !prs_fwd_o[0] && !prs_rev_o[0];
  endproperty
  a_shut: assert property (p_shut)
    else $error("press runs under shutdown alarm");

  property p_hist;
    |(alarm_reg & ~alarm_next) |=> hist_we_o && hist_mask_o != '0;
  endproperty
  a_hist: assert property (p_hist)
    else $error("cleared alarm not logged");

  property p_tgl;
    man[2] && wash_tgl_i[0] |=> vt_reg[0] != $past(vt_reg[0]);
  endproperty
  a_tgl: assert property (p_tgl)
    else $error("wash toggle ignored in manual");
endmodule

// file: hw/scc_pkg.sv
package scc_pkg;
  // Machine count: two screens (0,1) then two presses (2,3)
  localparam int NM       = 4;
  localparam int LW       = 12;  // Analog reading width
  localparam int TW       = 32;  // Time and runtime width
  localparam int CW       = 16;  // Event counter width
  localparam int OD       = 4;   // Overload timestamp slots per screen
  // Alarm vector layout, two bits per group, four for emergency stop
  localparam int A_OVL    = 0;   // Screen overload stop
  localparam int A_HLV    = 2;   // Upstream high level warning
  localparam int A_EST    = 4;   // Emergency stop, four machines
  localparam int A_WRN    = 8;   // Press current warning
  localparam int A_SHT    = 10;  // Press current shutdown
  localparam int A_LOW    = 12;  // Press low current, spiral breakage
  localparam int A_CRT    = 14;  // Press left out of automatic
  localparam int NA       = 16;
  // Reset values
  localparam logic [TW-1:0] RST_T = 32'h0000_0000;
  localparam logic [CW-1:0] RST_C = 16'h0000;

  // Screen sequence states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ROT  = 3'b010,
    S_REV  = 3'b100
  } scc_scr_e;

  // Press sequence states
  typedef enum logic [1:0] {
    P_IDLE = 2'b01,
    P_RUN  = 2'b10
  } scc_prs_e;

  // Field pins, all asynchronous to the scan clock
  typedef struct packed {
    logic [NM-1:0] man;     // local_mode_selector at manual
    logic [NM-1:0] aut;     // local_mode_selector at automatic
    logic [NM-1:0] fwd;     // Momentary direction switch forward
    logic [NM-1:0] rev;     // Momentary direction switch reverse
    logic [NM-1:0] estop;   // Emergency stop latched in
    logic [1:0]    home;    // Screen home proximity switch
    logic          rst_btn; // Panel alarm reset push button
  } scc_pin_s;

  // Operator settings
  typedef struct packed {
    logic [LW-1:0] torque_thr; // Screen overload threshold
    logic [TW-1:0] rev_time;   // Overload reverse interval, cycles
    logic [TW-1:0] ovl_win;    // Overload window, cycles
    logic [2:0]    ovl_lim;    // Overload events that stop a screen
    logic [LW-1:0] cur_warn;   // motor_current_sensor warning level
    logic [LW-1:0] cur_shut;   // motor_current_sensor shutdown level
    logic [LW-1:0] cur_low;    // motor_current_sensor low level
    logic [LW-1:0] hi_warn;    // High level warning setpoint
    logic [LW-1:0] alt_high;   // Alternation suspend level
    logic [LW-1:0] cont_off;   // Continuous-run shut-off level
    logic [TW-1:0] alt_dly;    // Delay after a rotation, cycles
    logic [TW-1:0] crt_dly;    // Press out-of-auto delay, cycles
    logic [TW-1:0] cyc_time;   // Press treatment cycle, cycles
    logic [TW-1:0] wash_time;  // Wash valve time in a cycle, cycles
    logic          alt_en;     // Alternating start enable
  } scc_cfg_s;
endpackage

// file: sim/scc_field.sv
`timescale 1ns/1ps
// Field side: selectors, switches, mushrooms and the screen home cams
module scc_field (
  // Clock and screen drive
  input  wire logic              clk_sys_i,
  input  wire logic [1:0]        scr_fwd_i,
  // Operator actions, home bits unused
  input  wire scc_pkg::scc_pin_s act_i,
  // Pins towards the controller
  output scc_pkg::scc_pin_s      pin_o
);
  import scc_pkg::*;
  logic [1:0][3:0] cam_reg = '0; // Cam position, one turn in 16 cycles
  // Cam only moves while the motor is driven forward
  always_ff @(posedge clk_sys_i) begin
    for (int k = 0; k < 2; k++) begin
      if (scr_fwd_i[k]) begin
        cam_reg[k] <= cam_reg[k] + 4'h1;
      end
    end
  end
  // Mushroom stays latched until the operator pulls it out
  always_comb begin
    pin_o = act_i;
    for (int k = 0; k < 2; k++) begin
      pin_o.home[k] = (cam_reg[k] == 4'hF);
    end
  end
endmodule

// file: sim/scc_ctrl_bench.sv
`timescale 1ns/1ps
module scc_ctrl_bench;
  import scc_pkg::*;
  logic             clk_sys_i = 1'b0;
  logic             rst_n_i = 1'b0;
  scc_pin_s         act;
  scc_pin_s         pin;
  scc_cfg_s         cfg;
  logic [1:0][11:0] trq;
  logic [1:0][11:0] cur;
  logic [1:0]       sf, sr, pf, pr, wv, fv, wt, ft, st;
  logic [15:0]      al;
  logic [15:0]      q[$];   // Expected drive snapshots, oldest first
  int               error_cnt = 0;
  int               check_count = 0;
  int               cyc = 0;
  integer           seed = 32'hC845F280;
  logic             ovl = 1'b0; // Pushes screen 0 torque past threshold
  event             smp;
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  scc_field i_fld (.clk_sys_i(clk_sys_i), .scr_fwd_i(sf), .act_i(act),
    .pin_o(pin));
  scc_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pin_i(pin),
    .cfg_i(cfg), .torque_i(trq), .cur_i(cur), .level_i(24'h000000),
    .start_req_i(2'b00), .scr_trig_i(st), .prs_trig_i(2'b00),
    .wash_tgl_i(wt), .flush_tgl_i(ft), .alarm_clr_i(1'b0),
    .scr_fwd_o(sf), .scr_rev_o(sr), .prs_fwd_o(pf), .prs_rev_o(pr),
    .wash_vlv_o(wv), .flush_vlv_o(fv), .alarm_o(al), .hist_we_o(),
    .hist_mask_o(), .hist_time_o(), .starts_o(), .runtime_o(),
    .cycles_o(), .alt_turn_o());
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Note the expected snapshot after n falling edges
  task automatic expect_out(input int n, input logic [15:0] v);
    repeat (n) @(negedge clk_sys_i);
    q.push_back(v);
    -> smp;
  endtask
  // Snapshot: estop alarms, then every drive pair
  task automatic chk_out(input logic [15:0] e);
    logic [15:0] g;
    g = {al[A_EST +: 4], sf, sr, pf, pr, wv, fv};
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] drives exp %h got %h", e, g);
    end
  endtask
  // One-cycle command pulse on unit 0
  task automatic pulse(ref logic [1:0] s);
    s = 2'b01;
    @(negedge clk_sys_i);
    s = 2'b00;
  endtask
  always @(smp) chk_out(q.pop_front());
  // Random readings kept clear of every alarm level; hang guard
  always @(negedge clk_sys_i) begin
    trq <= {12'($random(seed)) & 12'h7FF,
            ovl ? 12'hF00 : 12'($random(seed)) & 12'h7FF};
    cur <= {12'h200 | 12'($random(seed)) & 12'h3FF, 12'h200};
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    act = '0;
    cfg = '0;
    cfg.torque_thr = 12'hF00;
    cfg.cur_warn = 12'hC00;
    cfg.cur_shut = 12'hE00;
    cfg.hi_warn = 12'hFFF;
    cfg.alt_high = 12'hFFF;
    cfg.rev_time = 32'h0000_0008;
    cfg.ovl_win = 32'h0000_0190;
    cfg.ovl_lim = 3'h2; // A zero limit would trip at once
    {wt, ft, st} = 6'h00;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    act.man[0] = 1'b1;
    act.fwd[0] = 1'b1;
    expect_out(5, 16'h0400);
    act.fwd[0] = 1'b0;
    act.rev[0] = 1'b1;
    expect_out(5, 16'h0100);
    act.estop[0] = 1'b1;
    expect_out(5, 16'h1000);
    act.estop[0] = 1'b0;
    act.rev[0] = 1'b0;
    expect_out(5, 16'h0000);
    act.man[2] = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    pulse(wt);
    expect_out(4, 16'h0004);
    pulse(wt);
    expect_out(4, 16'h0000);
    act.fwd[2] = 1'b1;
    expect_out(5, 16'h0040);
    act.fwd[2] = 1'b0;
    act.rev[2] = 1'b1;
    expect_out(5, 16'h0010);
    act.rev[2] = 1'b0;
    act.man[2] = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    pulse(ft);
    expect_out(4, 16'h0000);
    act.man[0] = 1'b0;
    act.aut[0] = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    pulse(st);
    expect_out(3, 16'h0400);
    expect_out(25, 16'h0000);
    // Overload mid-rotation reverses, then resumes; a second one trips
    pulse(st);
    ovl <= 1'b1;
    expect_out(5, 16'h0100);
    ovl <= 1'b0;
    expect_out(7, 16'h0400);
    ovl <= 1'b1;
    expect_out(5, 16'h0000);
    ovl <= 1'b0;
    // Press jogged by hand while its emergency stop is in
    act.man[2] = 1'b1;
    act.fwd[2] = 1'b1;
    act.estop[2] = 1'b1;
    expect_out(5, 16'h4000);
    @(negedge clk_sys_i);
    stop_test();
  end
endmodule
